//--- fpet_params.svh
`ifndef FPET_PARAMS_SVH
`define FPET_PARAMS_SVH

// Single word program: operation clock periods and bus clock periods
`define FPET_SWP_OP_CYC 9
`define FPET_SWP_BUS_CYC 25
// Consecutive burst word
`define FPET_BWP_OP_CYC 4
`define FPET_BWP_BUS_CYC 9
`define FPET_BURST_MAX 32
// Erase durations in operation clock periods, and sector size in bytes
`define FPET_ERA_OP_CYC 4000
`define FPET_MASS_OP_CYC 20000
`define FPET_SECTOR_BYTES 512
// Blank check
`define FPET_CHK_SETUP_CYC 10
`define FPET_CHK_WORDS 32768
// Divider reset value
`define FPET_DIV_RESET 8'h00_7C

`endif

//--- fpet_pkg.sv
package fpet_pkg;
    typedef enum logic [2:0] {
        FPET_CMD_NONE,
        FPET_CMD_PROGRAM,
        FPET_CMD_SECTOR_ERASE,
        FPET_CMD_MASS_ERASE,
        FPET_CMD_BLANK_CHECK
    } fpet_cmd_e;

    typedef enum logic [2:0] {
        FPET_IDLE,
        FPET_PROG_OP,
        FPET_PROG_BUS,
        FPET_ERASE,
        FPET_CHECK_SETUP,
        FPET_CHECK_SCAN
    } fpet_state_e;
endpackage

//--- fpet_sequencer.sv
`timescale 1ns/1ns
`include "fpet_params.svh"
// Notes on behaviour
// - Burst of up to 32 words in one row while next word is queued early.
// - Each burst word after the first: 4 operation clocks plus 9 bus clocks.
// - Full row burst: one single-word time plus 31 burst-word times.
// - Sector erase of 512 bytes lasts 4000 operation clocks, no setup.
// - Mass erase lasts 20000 operation clocks, no setup.
// - Blank check scans upward from word zero, stops at first non-blank word.
// - Blank check: one word per bus clock plus 10 setup cycles.
// - Blank check lasts at least 11, at most 32778 bus cycles.
// - Single word program: 9 operation clocks plus 25 bus clocks.
module fpet_sequencer #(
    parameter int ADDR_W = 15,
    parameter int ERA_OP_CYC = `FPET_ERA_OP_CYC,
    parameter int MASS_OP_CYC = `FPET_MASS_OP_CYC,
    parameter int CHK_WORDS = `FPET_CHK_WORDS
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [7:0] flash_clock_divider_i,
    input wire logic cmd_valid_i,
    input wire fpet_pkg::fpet_cmd_e cmd_i,
    input wire logic [ADDR_W-1:0] cmd_addr_i,
    input wire logic done_clear_i,
    input wire logic word_blank_i,
    output logic cmd_ready_o,
    output logic busy_o,
    output logic done_o,
    output logic check_fail_o,
    output logic [ADDR_W-1:0] check_addr_o,
    output logic prog_strobe_o,
    output logic [ADDR_W-1:0] prog_addr_o
);
    import fpet_pkg::*;

    // ************************************************************
    // Operation clock tick from the divider
    // ************************************************************
    logic [7:0] div_cnt_reg, div_cnt_next;
    logic op_tick_reg, op_tick_next;

    always_comb begin
        div_cnt_next = div_cnt_reg + 8'h01;
        op_tick_next = 1'b0;
        if (div_cnt_reg >= flash_clock_divider_i) begin
            div_cnt_next = 8'h00;
            op_tick_next = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            div_cnt_reg <= 8'h00;
            op_tick_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            op_tick_reg <= op_tick_next;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    fpet_state_e state_reg, state_next;
    logic [15:0] op_cnt_reg, op_cnt_next;
    logic [15:0] bus_cnt_reg, bus_cnt_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [5:0] burst_reg, burst_next;
    logic queued_reg, queued_next;
    logic [ADDR_W-1:0] qaddr_reg, qaddr_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic fail_reg, fail_next;
    logic strobe_reg, strobe_next;
    logic ready_reg, ready_next;
    logic done_set;
    logic same_row;
    logic can_queue;
    logic cmd_kind_mass;
    logic mass_reg, mass_next;

    // A row holds 32 words; queued word must share the row of the current one
    assign same_row = (cmd_addr_i[ADDR_W-1:5] == addr_reg[ADDR_W-1:5]);
    assign can_queue = (state_reg == FPET_PROG_OP || state_reg == FPET_PROG_BUS)
        && !queued_reg && same_row && (burst_reg < 6'(`FPET_BURST_MAX));

    always_comb begin
        state_next = state_reg;
        op_cnt_next = op_cnt_reg;
        bus_cnt_next = bus_cnt_reg;
        addr_next = addr_reg;
        burst_next = burst_reg;
        queued_next = queued_reg;
        qaddr_next = qaddr_reg;
        busy_next = busy_reg;
        fail_next = fail_reg;
        strobe_next = 1'b0;
        done_set = 1'b0;
        case (state_reg)
            FPET_IDLE: begin
                if (cmd_valid_i) begin
                    busy_next = 1'b1;
                    fail_next = 1'b0;
                    addr_next = cmd_addr_i;
                    op_cnt_next = 16'h0000;
                    bus_cnt_next = 16'h0000;
                    case (cmd_i)
                        FPET_CMD_PROGRAM: begin
                            burst_next = 6'd1;
                            strobe_next = 1'b1;
                            state_next = FPET_PROG_OP;
                        end
                        FPET_CMD_SECTOR_ERASE: begin
                            // Align to sector of 512 bytes (256 words)
                            addr_next = cmd_addr_i & ~ADDR_W'(`FPET_SECTOR_BYTES / 2 - 1);
                            state_next = FPET_ERASE;
                        end
                        FPET_CMD_MASS_ERASE: begin
                            addr_next = '0;
                            state_next = FPET_ERASE;
                        end
                        FPET_CMD_BLANK_CHECK: begin
                            addr_next = '0;
                            state_next = FPET_CHECK_SETUP;
                        end
                        default: busy_next = 1'b0;
                    endcase
                end
            end
            FPET_PROG_OP: begin
                // First word 9 op clocks, later burst words 4
                if (op_tick_reg) begin
                    op_cnt_next = op_cnt_reg + 16'h0001;
                    if (op_cnt_reg + 16'h0001 >= ((burst_reg == 6'd1) ?
                            16'(`FPET_SWP_OP_CYC) : 16'(`FPET_BWP_OP_CYC))) begin
                        state_next = FPET_PROG_BUS;
                        bus_cnt_next = 16'h0000;
                    end
                end
            end
            FPET_PROG_BUS: begin
                bus_cnt_next = bus_cnt_reg + 16'h0001;
                if (bus_cnt_reg + 16'h0001 >= ((burst_reg == 6'd1) ?
                        16'(`FPET_SWP_BUS_CYC) : 16'(`FPET_BWP_BUS_CYC))) begin
                    if (queued_reg || (cmd_valid_i && can_queue && cmd_i == FPET_CMD_PROGRAM)) begin
                        // Pipeline filled in time: continue burst
                        addr_next = queued_reg ? qaddr_reg : cmd_addr_i;
                        queued_next = 1'b0;
                        burst_next = burst_reg + 6'd1;
                        strobe_next = 1'b1;
                        op_cnt_next = 16'h0000;
                        state_next = FPET_PROG_OP;
                    end else begin
                        done_set = 1'b1;
                        state_next = FPET_IDLE;
                    end
                end
            end
            FPET_ERASE: begin
                if (op_tick_reg) begin
                    op_cnt_next = op_cnt_reg + 16'h0001;
                    if (32'(op_cnt_reg) + 1 >= ((cmd_kind_mass) ? MASS_OP_CYC : ERA_OP_CYC)) begin
                        done_set = 1'b1;
                        state_next = FPET_IDLE;
                    end
                end
            end
            FPET_CHECK_SETUP: begin
                bus_cnt_next = bus_cnt_reg + 16'h0001;
                if (bus_cnt_reg + 16'h0001 >= 16'(`FPET_CHK_SETUP_CYC)) begin
                    state_next = FPET_CHECK_SCAN;
                end
            end
            FPET_CHECK_SCAN: begin
                // One word per bus clock
                if (!word_blank_i) begin
                    fail_next = 1'b1;
                    done_set = 1'b1;
                    state_next = FPET_IDLE;
                end else if (32'(addr_reg) + 1 >= CHK_WORDS) begin
                    done_set = 1'b1;
                    state_next = FPET_IDLE;
                end else begin
                    addr_next = addr_reg + ADDR_W'(1);
                end
            end
            default: state_next = FPET_IDLE;
        endcase
        if (state_reg == FPET_PROG_OP && cmd_valid_i && can_queue && cmd_i == FPET_CMD_PROGRAM) begin
            queued_next = 1'b1;
            qaddr_next = cmd_addr_i;
        end
        if (done_set) begin
            busy_next = 1'b0;
        end
        // Set wins over a simultaneous clear
        done_next = done_set | (done_reg & ~done_clear_i);
        if (cmd_valid_i && state_reg == FPET_IDLE) begin
            done_next = 1'b0;
        end
        ready_next = (state_next == FPET_IDLE) ||
            ((state_next == FPET_PROG_OP) && !queued_next);
    end

    // Erase kind latched at launch
    assign cmd_kind_mass = mass_reg;
    always_comb begin
        mass_next = mass_reg;
        if (state_reg == FPET_IDLE && cmd_valid_i) begin
            mass_next = (cmd_i == FPET_CMD_MASS_ERASE);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            state_reg <= FPET_IDLE;
            op_cnt_reg <= 16'h0000;
            bus_cnt_reg <= 16'h0000;
            addr_reg <= '0;
            burst_reg <= 6'd0;
            queued_reg <= 1'b0;
            qaddr_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            strobe_reg <= 1'b0;
            ready_reg <= 1'b1;
            mass_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_cnt_reg <= op_cnt_next;
            bus_cnt_reg <= bus_cnt_next;
            addr_reg <= addr_next;
            burst_reg <= burst_next;
            queued_reg <= queued_next;
            qaddr_reg <= qaddr_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            fail_reg <= fail_next;
            strobe_reg <= strobe_next;
            ready_reg <= ready_next;
            mass_reg <= mass_next;
        end
    end

    assign cmd_ready_o = ready_reg;
    assign busy_o = busy_reg;
    assign done_o = done_reg;
    assign check_fail_o = fail_reg;
    assign check_addr_o = addr_reg;
    assign prog_strobe_o = strobe_reg;
    assign prog_addr_o = addr_reg;
endmodule

//--- fpet_props.sv
`timescale 1ns/1ns
module fpet_props
    import fpet_pkg::*;
#(
    parameter int ADDR_W = 15,
    parameter int ERA_OP_CYC = 4000,
    parameter int MASS_OP_CYC = 20000,
    parameter int CHK_WORDS = 32768
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [7:0] flash_clock_divider_i,
    input wire logic cmd_valid_i,
    input wire fpet_pkg::fpet_cmd_e cmd_i,
    input wire logic [ADDR_W-1:0] cmd_addr_i,
    input wire logic done_clear_i,
    input wire logic word_blank_i,
    input wire logic cmd_ready_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic check_fail_o,
    input wire logic [ADDR_W-1:0] check_addr_o,
    input wire logic prog_strobe_o,
    input wire logic [ADDR_W-1:0] prog_addr_o
);
    int cnt_reg, cnt_next, words_reg, words_next, tick;
    fpet_cmd_e cmd_reg, cmd_next;
    assign tick = int'(flash_clock_divider_i) + 1;
    always_comb begin
        cnt_next = busy_o ? cnt_reg + 1 : 0;
        words_next = busy_o ? words_reg + int'(prog_strobe_o) : 0;
        cmd_next = (!busy_o && cmd_valid_i && cmd_ready_o) ? cmd_i : cmd_reg;
    end
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            cnt_reg <= 0;
            words_reg <= 0;
            cmd_reg <= FPET_CMD_NONE;
        end else begin
            cnt_reg <= cnt_next;
            words_reg <= words_next;
            cmd_reg <= cmd_next;
        end
    end
    // Tick phase is free running, so each word may lose up to one tick
    function automatic logic near(int v, int e, int s);
        return v >= e - s && v <= e + s;
    endfunction
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_launch;
        !busy_o && cmd_valid_i && cmd_ready_o && cmd_i != FPET_CMD_NONE;
    endsequence
    sequence s_fin(fpet_cmd_e c);
        $fell(busy_o) ##0 cmd_reg == c;
    endsequence
    property p_launch; s_launch |=> busy_o; endproperty
    property p_done; $fell(busy_o) |-> done_o; endproperty
    property p_single;
        s_fin(FPET_CMD_PROGRAM) ##0 words_reg == 1 |-> near(cnt_reg, 9 * tick + 25, tick + 1);
    endproperty
    property p_row;
        s_fin(FPET_CMD_PROGRAM) ##0 words_reg == 32
            |-> near(cnt_reg, 9 * tick + 25 + 31 * (4 * tick + 9), 32 * (tick - 1) + 2);
    endproperty
    property p_gap; prog_strobe_o |=> !prog_strobe_o [*8]; endproperty
    property p_sector;
        s_fin(FPET_CMD_SECTOR_ERASE) |-> near(cnt_reg, ERA_OP_CYC * tick, tick + 1);
    endproperty
    property p_mass;
        s_fin(FPET_CMD_MASS_ERASE) |-> near(cnt_reg, MASS_OP_CYC * tick, tick + 1);
    endproperty
    property p_check;
        s_fin(FPET_CMD_BLANK_CHECK)
            |-> near(cnt_reg, check_fail_o ? 11 + int'(check_addr_o) : 10 + CHK_WORDS, 2);
    endproperty
    property p_fail_word;
        $rose(done_o) && check_fail_o && cmd_reg == FPET_CMD_BLANK_CHECK |-> !word_blank_i;
    endproperty
    property p_refuse; busy_o && cmd_reg != FPET_CMD_PROGRAM |-> !cmd_ready_o; endproperty
    property p_clear; done_o && done_clear_i && !busy_o && !cmd_valid_i |=> !done_o; endproperty
    property p_strobe; prog_strobe_o |-> busy_o && cmd_reg == FPET_CMD_PROGRAM; endproperty
    a_launch: assert property (p_launch) else $error("no busy after launch");
    a_done: assert property (p_done) else $error("no done at completion");
    a_single: assert property (p_single) else $error("single word time");
    a_row: assert property (p_row) else $error("row burst time");
    a_gap: assert property (p_gap) else $error("word strobes too close");
    a_sector: assert property (p_sector) else $error("sector erase time");
    a_mass: assert property (p_mass) else $error("mass erase time");
    a_check: assert property (p_check) else $error("blank check time");
    a_fail_word: assert property (p_fail_word) else $error("stop word is blank");
    a_refuse: assert property (p_refuse) else $error("ready while busy");
    a_clear: assert property (p_clear) else $error("done not cleared");
    a_strobe: assert property (p_strobe) else $error("stray strobe");
endmodule

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import fpet_pkg::*;
    localparam int ERA = 20, MASS = 40, WORDS = 64;
    typedef struct {int lo; int hi; logic chk; logic fail; logic [14:0] at;} fpet_exp_s;
    logic clock_i = 0, reset_n_i = 0, cmd_valid_i = 0, done_clear_i = 0, word_blank_i;
    logic [7:0] flash_clock_divider_i = 0;
    fpet_cmd_e cmd_i = FPET_CMD_NONE;
    logic [14:0] cmd_addr_i = 0, fail_at = 0, check_addr_o, prog_addr_o;
    logic cmd_ready_o, busy_o, done_o, check_fail_o, prog_strobe_o, busy_d = 0;
    int miscompares = 0, n_tests = 0, cyc = 0, dcnt = 0, t = 1;
    fpet_exp_s q_exp[$], e;
    logic [14:0] q_addr[$];
    // 25 MHz keeps the bus clock well above the floor for program and erase
    always #20 clock_i = ~clock_i;
    // Flash array model: every word is erased except the one at fail_at
    assign word_blank_i = check_addr_o != fail_at;
    fpet_sequencer #(.ERA_OP_CYC(ERA), .MASS_OP_CYC(MASS), .CHK_WORDS(WORDS)) fpet_sequencer_i (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .flash_clock_divider_i(flash_clock_divider_i),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_addr_i(cmd_addr_i),
        .done_clear_i(done_clear_i), .word_blank_i(word_blank_i), .cmd_ready_o(cmd_ready_o),
        .busy_o(busy_o), .done_o(done_o), .check_fail_o(check_fail_o),
        .check_addr_o(check_addr_o), .prog_strobe_o(prog_strobe_o), .prog_addr_o(prog_addr_o));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("compares=%0d mismatches=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic note(input int x, input int s, input logic c, input logic f, input logic [14:0] a);
        q_exp.push_back('{x - s, x + s, c, f, a});
    endtask
    task automatic issue(input fpet_cmd_e c, input logic [14:0] a);
        cmd_valid_i <= 1;
        cmd_i <= c;
        cmd_addr_i <= a;
        do @(posedge clock_i); while (!cmd_ready_o);
    endtask
    task automatic finish_op;
        cmd_valid_i <= 0;
        repeat (2) @(posedge clock_i);
        while (busy_o) @(posedge clock_i);
        repeat (2) @(posedge clock_i);
    endtask
    task automatic run_prog(input int n);
        logic [14:0] base;
        base = 15'($urandom) & 15'h7FE0;
        note(9 * t + 25 + (n - 1) * (4 * t + 9), n * (t - 1) + 2, 0, 0, 0);
        for (int w = 0; w < n; w++) begin
            q_addr.push_back(base + 15'(w));
            issue(FPET_CMD_PROGRAM, base + 15'(w));
        end
        finish_op;
    endtask
    task automatic run_check(input logic [14:0] at);
        fail_at <= at;
        note(at < WORDS ? 11 + int'(at) : 10 + WORDS, 2, 1, at < WORDS, at);
        issue(FPET_CMD_BLANK_CHECK, 0);
        finish_op;
    endtask
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        busy_d <= busy_o;
        dcnt <= busy_o ? dcnt + 1 : 0;
        if (prog_strobe_o) check(prog_addr_o, q_addr.size() ? q_addr.pop_front() : 'x);
        if (busy_d && !busy_o) begin
            if (q_exp.size() > 0) begin
                e = q_exp.pop_front();
            end else begin
                e = '{0, -1, 0, 0, 0};
            end
            check(dcnt >= e.lo && dcnt <= e.hi, 1);
            check(done_o, 1);
            if (e.chk) check(check_fail_o, e.fail);
            if (e.chk && e.fail) check(check_addr_o, e.at);
        end
        // Limit is tested last, since the closing report ends the run
        if (cyc > 20000) begin
            miscompares++;
            final_report;
        end
    end
    initial begin
        t = $urandom(70309);
        repeat (6) @(posedge clock_i);
        reset_n_i <= 1;
        for (int p = 0; p < 2; p++) begin
            flash_clock_divider_i <= 8'(2 * p);
            t = 2 * p + 1;
            @(posedge clock_i);
            run_prog(1);
            run_prog(32);
            note(ERA * t, t + 1, 0, 0, 0);
            issue(FPET_CMD_SECTOR_ERASE, 15'($urandom) & 15'h7F00);
            // A second command while busy must be ignored
            cmd_i <= FPET_CMD_MASS_ERASE;
            repeat (3) @(posedge clock_i);
            finish_op;
            note(MASS * t, t + 1, 0, 0, 0);
            issue(FPET_CMD_MASS_ERASE, 15'($urandom));
            finish_op;
            run_check(0);
            run_check(15'($urandom_range(62, 1)));
            run_check(15'h7FFF);
        end
        check(done_o, 1);
        done_clear_i <= 1;
        @(posedge clock_i);
        done_clear_i <= 0;
        @(posedge clock_i);
        check(done_o, 0);
        // Leftover notes mean an operation never showed busy
        check(q_exp.size(), 0);
        check(q_addr.size(), 0);
        final_report;
    end
endmodule
bind fpet_sequencer fpet_props #(.ADDR_W(ADDR_W), .ERA_OP_CYC(ERA_OP_CYC),
    .MASS_OP_CYC(MASS_OP_CYC), .CHK_WORDS(CHK_WORDS)) fpet_props_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .flash_clock_divider_i(flash_clock_divider_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_addr_i(cmd_addr_i),
    .done_clear_i(done_clear_i), .word_blank_i(word_blank_i), .cmd_ready_o(cmd_ready_o),
    .busy_o(busy_o), .done_o(done_o), .check_fail_o(check_fail_o),
    .check_addr_o(check_addr_o), .prog_strobe_o(prog_strobe_o), .prog_addr_o(prog_addr_o));
